// ---- hdl/hsq_edge_det.sv ----
/*
  hsq_edge_det: samples N switch inputs and flags their edges.
  assumes: inputs already synchronous to mclk.
*/
`default_nettype none
module hsq_edge_det
  import hsq_pkg::*;
#(
  parameter int N = HSQ_SW_N
) (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // raw levels
  input wire logic [N-1:0] lvl_in,
  // sampled levels and edges
  output logic [N-1:0] lvl,
  output logic [N-1:0] rise,
  output logic [N-1:0] fall
);
  logic [N-1:0] cur_q, cur_d, prev_q, prev_d;
  // fill_q[1] says both samples were taken after reset; a switch already
  // active during reset would otherwise show a false rise
  logic [1:0] fill_q, fill_d;

  if (N < 1) begin : g_bad_n
    $error("hsq_edge_det: N must be at least 1");
  end

  always_comb begin
    cur_d = lvl_in;
    prev_d = cur_q;
    fill_d = {fill_q[0], 1'b1};
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      cur_q <= '0;
      prev_q <= '0;
      fill_q <= '0;
    end else begin
      cur_q <= cur_d;
      prev_q <= prev_d;
      fill_q <= fill_d;
    end
  end

  // edges compare two successive samples
  for (genvar i = 0; i < N; i++) begin : g_edge
    assign rise[i] = cur_q[i] & ~prev_q[i] & fill_q[1];
    assign fall[i] = ~cur_q[i] & prev_q[i] & fill_q[1];
  end

  assign lvl = cur_q;
endmodule // hsq_edge_det
`default_nettype wire

// ---- hdl/hsq_homing_seq.sv ----
/*
  hsq_homing_seq: homing sequencer for one axis, using the home switch
  and the positive limit switch as reversing switch.
  assumes: switch levels synchronous to mclk, active high; the drive
  follows motion and speed every cycle; axis_pos is the live position.
*/
`default_nettype none
module hsq_homing_seq
  import hsq_pkg::*;
#(
  parameter int SPEED_W = HSQ_SPEED_W,
  parameter int POS_W = HSQ_POS_W
) (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // command
  input wire logic start,
  input wire logic abort,
  input wire logic [1:0] mode,
  // speed settings
  input wire logic [SPEED_W-1:0] fast_speed,
  input wire logic [SPEED_W-1:0] creep_speed,
  // switches and position
  input wire hsq_sw_t sw,
  input wire logic [POS_W-1:0] axis_pos,
  // drive command
  output hsq_motion_t motion,
  output logic [SPEED_W-1:0] speed,
  // status
  output logic busy,
  output logic done,
  output logic fault,
  output logic [POS_W-1:0] home_pos,
  output logic home_valid
);

  if (SPEED_W < 1) begin : g_bad_speed
    $error("hsq_homing_seq: SPEED_W must be at least 1");
  end

  // build one sequence step
  function automatic hsq_step_t mk_step(hsq_state_t st, logic dir_pos, logic fast,
                                        logic want_rise);
    hsq_step_t s;
    s.state = st;
    s.dir_pos = dir_pos;
    s.fast = fast;
    s.want_rise = want_rise;
    return s;
  endfunction

  // the final approach on its target edge
  function automatic hsq_step_t final_step(logic dir_pos, logic want_rise);
    return mk_step(HSQ_ST_FINAL, dir_pos, 1'b0, want_rise);
  endfunction

  // switch sampling and edges
  logic [HSQ_SW_N-1:0] sw_lvl, sw_rise, sw_fall;
  logic home_lvl, home_rise, home_fall, lim_lvl, lim_rise;

  hsq_edge_det #(
    .N(HSQ_SW_N)
  ) u_edge (
    .mclk(mclk),
    .srst(srst),
    .lvl_in({sw.lim_pos, sw.home}),
    .lvl(sw_lvl),
    .rise(sw_rise),
    .fall(sw_fall)
  );

  assign home_lvl = sw_lvl[HSQ_SW_HOME_BIT];
  assign home_rise = sw_rise[HSQ_SW_HOME_BIT];
  assign home_fall = sw_fall[HSQ_SW_HOME_BIT];
  assign lim_lvl = sw_lvl[HSQ_SW_LIM_BIT];
  assign lim_rise = sw_rise[HSQ_SW_LIM_BIT];

  // sequence state
  hsq_state_t st_q, st_d;
  logic dir_q, dir_d;
  logic fast_q, fast_d;
  logic want_rise_q, want_rise_d;
  logic [1:0] mode_q, mode_d;
  logic capture, invalidate;
  hsq_step_t nx;

  // next step decoding
  always_comb begin
    nx = mk_step(st_q, dir_q, fast_q, want_rise_q);
    capture = 1'b0;
    invalidate = 1'b0;
    mode_d = mode_q;
    case (st_q)
      HSQ_ST_IDLE, HSQ_ST_DONE, HSQ_ST_FAULT: begin
        if (start) begin
          mode_d = mode;
          invalidate = 1'b1;
          if (home_lvl) begin
            case (mode)
              HSQ_MODE_LEFT_FALL: nx = final_step(1'b0, 1'b0);
              HSQ_MODE_LEFT_RISE: nx = mk_step(HSQ_ST_INSIDE, 1'b0, 1'b1, 1'b1);
              HSQ_MODE_RIGHT_RISE: nx = mk_step(HSQ_ST_INSIDE, 1'b1, 1'b1, 1'b1);
              default: nx = final_step(1'b1, 1'b0);
            endcase
          end else if (lim_lvl) begin
            // already sitting on the limit: reverse straight away
            nx = mk_step(HSQ_ST_BACK, 1'b0, 1'b1, 1'b0);
          end else begin
            nx = mk_step(HSQ_ST_OUT, 1'b1, 1'b1, 1'b0);
          end
        end
      end
      HSQ_ST_OUT: begin
        // home edge wins over a limit edge seen in the same sample
        if (home_rise) begin
          case (mode_q)
            HSQ_MODE_LEFT_FALL: nx = final_step(1'b0, 1'b0);
            HSQ_MODE_LEFT_RISE: begin
              nx = mk_step(HSQ_ST_DONE, 1'b1, 1'b1, 1'b1);
              capture = 1'b1;
            end
            HSQ_MODE_RIGHT_RISE: nx = mk_step(HSQ_ST_INSIDE, 1'b1, 1'b1, 1'b1);
            default: nx = final_step(1'b1, 1'b0);
          endcase
        end else if (lim_rise) begin
          nx = mk_step(HSQ_ST_BACK, 1'b0, 1'b1, 1'b0);
        end
      end
      HSQ_ST_BACK: begin
        if (home_rise) begin
          case (mode_q)
            HSQ_MODE_LEFT_FALL: nx = final_step(1'b0, 1'b0);
            HSQ_MODE_LEFT_RISE: nx = mk_step(HSQ_ST_INSIDE, 1'b0, 1'b1, 1'b1);
            HSQ_MODE_RIGHT_RISE: begin
              nx = mk_step(HSQ_ST_DONE, 1'b0, 1'b1, 1'b1);
              capture = 1'b1;
            end
            default: nx = final_step(1'b1, 1'b0);
          endcase
        end
      end
      HSQ_ST_INSIDE: begin
        // switch passed: reverse and creep back onto its rising edge
        if (home_fall) begin
          nx = final_step(~dir_q, 1'b1);
        end
      end
      HSQ_ST_FINAL: begin
        if (want_rise_q ? home_rise : home_fall) begin
          nx = mk_step(HSQ_ST_DONE, dir_q, 1'b0, want_rise_q);
          capture = 1'b1;
        end
      end
      default: nx = mk_step(HSQ_ST_IDLE, HSQ_DIR_RST, HSQ_FAST_RST, HSQ_WANT_RISE_RST);
    endcase
    // running positive into the limit means the edge was missed
    if ((st_q == HSQ_ST_INSIDE || st_q == HSQ_ST_FINAL || st_q == HSQ_ST_BACK)
        && lim_rise && dir_q && !capture) begin
      nx = mk_step(HSQ_ST_FAULT, dir_q, fast_q, want_rise_q);
    end
    if (abort) begin
      nx = mk_step(HSQ_ST_IDLE, dir_q, fast_q, want_rise_q);
      capture = 1'b0;
    end
    st_d = nx.state;
    dir_d = nx.dir_pos;
    fast_d = nx.fast;
    want_rise_d = nx.want_rise;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      st_q <= HSQ_ST_IDLE;
      dir_q <= HSQ_DIR_RST;
      fast_q <= HSQ_FAST_RST;
      want_rise_q <= HSQ_WANT_RISE_RST;
      mode_q <= HSQ_MODE_LEFT_FALL;
    end else begin
      st_q <= st_d;
      dir_q <= dir_d;
      fast_q <= fast_d;
      want_rise_q <= want_rise_d;
      mode_q <= mode_d;
    end
  end

  // drive outputs are registered so the drive never sees a glitch
  hsq_motion_t motion_q, motion_d;
  logic [SPEED_W-1:0] speed_q, speed_d;
  logic running;

  always_comb begin
    running = (st_d == HSQ_ST_OUT) || (st_d == HSQ_ST_BACK) ||
              (st_d == HSQ_ST_INSIDE) || (st_d == HSQ_ST_FINAL);
    motion_d.run = running;
    motion_d.dir_pos = dir_d;
    motion_d.fast = fast_d;
    speed_d = '0;
    if (running) begin
      speed_d = fast_d ? fast_speed : creep_speed;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      motion_q <= '0;
      speed_q <= '0;
    end else begin
      motion_q <= motion_d;
      speed_q <= speed_d;
    end
  end

  assign motion = motion_q;
  assign speed = speed_q;
  assign busy = motion_q.run;
  assign done = (st_q == HSQ_ST_DONE);
  assign fault = (st_q == HSQ_ST_FAULT);

  // home reference latch
  hsq_pos_latch #(
    .POS_W(POS_W)
  ) u_latch (
    .mclk(mclk),
    .srst(srst),
    .capture(capture),
    .invalidate(invalidate),
    .pos_in(axis_pos),
    .home_pos(home_pos),
    .home_valid(home_valid)
  );

endmodule // hsq_homing_seq
`default_nettype wire

// ---- hdl/hsq_pos_latch.sv ----
/*
  hsq_pos_latch: captures the axis position as home reference.
  assumes: pos_in is valid in the cycle of the capture strobe.
*/
`default_nettype none
module hsq_pos_latch
  import hsq_pkg::*;
#(
  parameter int POS_W = HSQ_POS_W
) (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // control
  input wire logic capture,
  input wire logic invalidate,
  input wire logic [POS_W-1:0] pos_in,
  // result
  output logic [POS_W-1:0] home_pos,
  output logic home_valid
);
  logic [POS_W-1:0] pos_q, pos_d;
  logic valid_q, valid_d;

  if (POS_W < 2) begin : g_bad_w
    $error("hsq_pos_latch: POS_W must be at least 2");
  end

  always_comb begin
    pos_d = pos_q;
    valid_d = valid_q;
    if (invalidate) begin
      valid_d = 1'b0;
    end
    // capture beats invalidate in the same cycle
    if (capture) begin
      pos_d = pos_in;
      valid_d = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      pos_q <= '0;
      valid_q <= 1'b0;
    end else begin
      pos_q <= pos_d;
      valid_q <= valid_d;
    end
  end

  assign home_pos = pos_q;
  assign home_valid = valid_q;
endmodule // hsq_pos_latch
`default_nettype wire

// ---- include/hsq_pkg.sv ----
/*
  hsq_pkg: shared types and constants of the homing sequencer.
  assumes: compiled before every hdl/ file that imports it.
*/
`default_nettype none
package hsq_pkg;

  // homing mode select, one code per edge choice
  localparam logic [1:0] HSQ_MODE_LEFT_FALL = 2'h0;
  localparam logic [1:0] HSQ_MODE_LEFT_RISE = 2'h1;
  localparam logic [1:0] HSQ_MODE_RIGHT_RISE = 2'h2;
  localparam logic [1:0] HSQ_MODE_RIGHT_FALL = 2'h3;

  // default widths
  localparam int HSQ_SPEED_W = 16;
  localparam int HSQ_POS_W = 32;
  localparam int HSQ_SW_N = 2;

  // bit positions in the sampled switch vector
  localparam int HSQ_SW_HOME_BIT = 0;
  localparam int HSQ_SW_LIM_BIT = 1;

  // reset values
  localparam logic HSQ_DIR_RST = 1'h1;
  localparam logic HSQ_FAST_RST = 1'h1;
  localparam logic HSQ_WANT_RISE_RST = 1'h0;

  // gray coded along the usual path idle-out-inside-final-done
  typedef enum logic [2:0] {
    HSQ_ST_IDLE = 3'h0,
    HSQ_ST_OUT = 3'h1,
    HSQ_ST_INSIDE = 3'h3,
    HSQ_ST_FINAL = 3'h2,
    HSQ_ST_DONE = 3'h6,
    HSQ_ST_BACK = 3'h5,
    HSQ_ST_FAULT = 3'h4
  } hsq_state_t;

  typedef struct packed {
    logic home;
    logic lim_pos;
  } hsq_sw_t;

  // one step of the sequence: where to go and how to move there
  typedef struct packed {
    hsq_state_t state;
    logic dir_pos;
    logic fast;
    logic want_rise;
  } hsq_step_t;

  typedef struct packed {
    logic run;
    logic dir_pos;
    logic fast;
  } hsq_motion_t;

endpackage : hsq_pkg
`default_nettype wire

// ---- verif/hsq_axis_model.sv ----
/*
  hsq_axis_model: axis with home cam at 100..199 and limit from 400.
  assumes: one motion step per mclk cycle; bench presets the position.
*/
`default_nettype none
module hsq_axis_model
  import hsq_pkg::*;
#(
  parameter int POS_W = HSQ_POS_W
) (
  // clock
  input wire logic mclk,
  // drive command and preset
  input wire hsq_motion_t motion,
  input wire logic load,
  input wire logic [POS_W-1:0] load_pos,
  // switches and position
  output hsq_sw_t sw,
  output logic [POS_W-1:0] axis_pos
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [POS_W-1:0] step;
  // fast steps four counts so the design must cope with overshoot
  always_comb step = motion.fast ? POS_W'(3'h4) : POS_W'(3'h1);
  always_ff @(posedge mclk) begin
    if (load) begin
      axis_pos <= load_pos;
    end else if (motion.run) begin
      axis_pos <= motion.dir_pos ? axis_pos + step : axis_pos - step;
    end
  end
  assign sw.home = axis_pos >= 32'h64 && axis_pos <= 32'hC7;
  assign sw.lim_pos = axis_pos >= 32'h190;
endmodule // hsq_axis_model
`default_nettype wire

// ---- verif/hsq_homing_seq_sva.sv ----
/*
  hsq_homing_seq_sva: port checks of the homing sequencer.
  assumes: bound to hsq_homing_seq; speed settings held steady.
*/
`default_nettype none
module hsq_homing_seq_sva
  import hsq_pkg::*;
#(
  parameter int SPEED_W = HSQ_SPEED_W,
  parameter int POS_W = HSQ_POS_W
) (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // command and settings
  input wire logic start,
  input wire logic abort,
  input wire logic [1:0] mode,
  input wire logic [SPEED_W-1:0] fast_speed,
  input wire logic [SPEED_W-1:0] creep_speed,
  input wire hsq_sw_t sw,
  input wire logic [POS_W-1:0] axis_pos,
  // drive command and status
  input wire hsq_motion_t motion,
  input wire logic [SPEED_W-1:0] speed,
  input wire logic busy,
  input wire logic done,
  input wire logic fault,
  input wire logic [POS_W-1:0] home_pos,
  input wire logic home_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);
  wire logic go = !busy && start && !abort;

  property p_fast_speed;
    motion.run && motion.fast |-> speed == $past(fast_speed);
  endproperty
  a_fast_speed: assert property (p_fast_speed) else $error("fast speed wrong");

  property p_creep_speed;
    motion.run && !motion.fast |-> speed == $past(creep_speed);
  endproperty
  a_creep_speed: assert property (p_creep_speed) else $error("creep speed wrong");

  property p_start_clear;
    go && !sw.home && !$past(sw.home) && !sw.lim_pos && !$past(sw.lim_pos)
      |=> motion.run && motion.dir_pos && motion.fast;
  endproperty
  a_start_clear: assert property (p_start_clear) else $error("clear start wrong");

  // direction from mode bit 1, fast for the two rising modes
  property p_start_home;
    go && sw.home && $past(sw.home) |=> motion.run && motion.dir_pos == $past(mode[1])
      && motion.fast == ($past(mode[0]) ^ $past(mode[1]));
  endproperty
  a_start_home: assert property (p_start_home) else $error("home start wrong");

  property p_limit_rev;
    motion.run && motion.dir_pos && motion.fast && !sw.home && $rose(sw.lim_pos)
      |-> ##[1:3] (motion.run && !motion.dir_pos && motion.fast);
  endproperty
  a_limit_rev: assert property (p_limit_rev) else $error("no limit reversal");

  property p_done_latch;
    $rose(done) |-> !busy && !(|speed) && home_valid
      && (home_pos == $past(axis_pos) || home_pos == $past(axis_pos, 2));
  endproperty
  a_done_latch: assert property (p_done_latch) else $error("home not latched");

  property p_abort;
    abort |=> !busy && !done && !motion.run;
  endproperty
  a_abort: assert property (p_abort) else $error("abort ignored");

  property p_fault_stop;
    fault |-> !busy && !(|speed);
  endproperty
  a_fault_stop: assert property (p_fault_stop) else $error("fault left axis moving");

  // with no switch change for three samples no edge can be pending
  property p_sw_quiet;
    (busy && !abort && $stable(sw)) [*3] |=> $stable(motion);
  endproperty
  a_sw_quiet: assert property (p_sw_quiet) else $error("motion moved alone");
endmodule // hsq_homing_seq_sva
`default_nettype wire

// ---- verif/test_hsq_homing_seq.sv ----
/*
  test_hsq_homing_seq: runs every mode from below, on and above the home cam.
  assumes: hsq_axis_model geometry; home within 16 counts of its edge.
*/
`default_nettype none
module test_hsq_homing_seq
  import hsq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'h0, srst = 1'h1, start = 1'h0, abort = 1'h0, load = 1'h1;
  logic [1:0] mode = 2'h0;
  logic [15:0] fast_speed = 16'h0400, creep_speed = 16'h0040, speed;
  logic [31:0] load_pos = 32'h0, axis_pos, home_pos;
  hsq_sw_t sw;
  hsq_motion_t motion;
  logic busy, done, fault, home_valid, last_dir = 1'h1, had_run = 1'h0, saw_creep = 1'h0;
  int mismatches = 0, num_checks = 0, rev = 0, cyc = 0;

  always #5 mclk = ~mclk;
  hsq_homing_seq hsq_homing_seq_inst (.mclk(mclk), .srst(srst), .start(start),
    .abort(abort), .mode(mode), .fast_speed(fast_speed), .creep_speed(creep_speed),
    .sw(sw), .axis_pos(axis_pos), .motion(motion), .speed(speed), .busy(busy),
    .done(done), .fault(fault), .home_pos(home_pos), .home_valid(home_valid));
  hsq_axis_model hsq_axis_model_inst (.mclk(mclk), .motion(motion), .load(load),
    .load_pos(load_pos), .sw(sw), .axis_pos(axis_pos));

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      tally_and_finish();
    end
    if (motion.run === 1'h1) begin
      if (had_run && motion.dir_pos !== last_dir) rev++;
      if (motion.fast === 1'h0) saw_creep = 1'h1;
      had_run = 1'h1;
      last_dir = motion.dir_pos;
    end
  end

  task automatic chk1(string n, logic e, logic g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chkn(string n, int e, int g);
    num_checks++;
    if (g != e) begin
      mismatches++;
      $display("mismatch %s expected %0d seen %0d", n, e, g);
    end
  endtask
  task automatic chk_near(string n, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (((g + 32'h10 >= e) && (g <= e + 32'h10)) !== 1'h1) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  // one homing run from preset p0; d f first direction and speed, r reversals
  task automatic home_run(logic [1:0] m, logic [31:0] p0, logic d, logic f, int r,
      logic c, logic [31:0] h);
    int i;
    load = 1'h1;
    load_pos = p0;
    @(posedge mclk) #1 load = 1'h0;
    repeat (3) @(posedge mclk);
    #1;
    mode = m;
    start = 1'h1;
    rev = 0;
    had_run = 1'h0;
    saw_creep = 1'h0;
    @(posedge mclk) #1 start = 1'h0;
    chk1("dir", d, motion.dir_pos);
    chk1("fast", f, motion.fast);
    for (i = 0; i < 600 && done !== 1'h1; i++) begin
      @(posedge mclk);
      #1;
    end
    chk1("done", 1'h1, done);
    chk1("valid", 1'h1, home_valid);
    chk1("fault", 1'h0, fault);
    chk1("creep", c, saw_creep);
    chkn("reversals", r, rev);
    chk_near("home", h, home_pos);
  endtask

  task automatic test_clear_start;
    home_run(2'h0, 32'h0, 1'h1, 1'h1, 1, 1'h1, 32'h64);
    home_run(2'h1, 32'h0, 1'h1, 1'h1, 0, 1'h0, 32'h64);
    home_run(2'h2, 32'h0, 1'h1, 1'h1, 1, 1'h1, 32'hC8);
    home_run(2'h3, 32'h0, 1'h1, 1'h1, 0, 1'h1, 32'hC8);
    $display("test_clear_start done");
  endtask
  task automatic test_home_start;
    home_run(2'h0, 32'h96, 1'h0, 1'h0, 0, 1'h1, 32'h64);
    home_run(2'h1, 32'h96, 1'h0, 1'h1, 1, 1'h1, 32'h64);
    home_run(2'h2, 32'h96, 1'h1, 1'h1, 1, 1'h1, 32'hC8);
    home_run(2'h3, 32'h96, 1'h1, 1'h0, 0, 1'h1, 32'hC8);
    $display("test_home_start done");
  endtask
  task automatic test_limit_start;
    home_run(2'h0, 32'h12C, 1'h1, 1'h1, 1, 1'h1, 32'h64);
    home_run(2'h1, 32'h12C, 1'h1, 1'h1, 2, 1'h1, 32'h64);
    home_run(2'h2, 32'h12C, 1'h1, 1'h1, 1, 1'h0, 32'hC8);
    home_run(2'h3, 32'h12C, 1'h1, 1'h1, 2, 1'h1, 32'hC8);
    $display("test_limit_start done");
  endtask
  task automatic test_abort;
    abort = 1'h1;
    @(posedge mclk) #1 abort = 1'h0;
    chk1("done", 1'h0, done);
    mode = 2'h0;
    start = 1'h1;
    @(posedge mclk) #1 start = 1'h0;
    repeat (2) @(posedge mclk);
    #1;
    chk1("valid", 1'h0, home_valid);
    abort = 1'h1;
    @(posedge mclk) #1 abort = 1'h0;
    chk1("busy", 1'h0, busy);
    chk1("done", 1'h0, done);
    $display("test_abort done");
  endtask
  // limit reached on the final creep toward a rising edge must stop the axis
  task automatic test_fault;
    int i;
    load = 1'h1;
    load_pos = 32'h64;
    @(posedge mclk) #1 load = 1'h0;
    repeat (3) @(posedge mclk);
    #1;
    mode = 2'h1;
    start = 1'h1;
    @(posedge mclk) #1 start = 1'h0;
    for (i = 0; i < 20 && !(motion.dir_pos === 1'h1 && motion.fast === 1'h0); i++) begin
      @(posedge mclk);
      #1;
    end
    load = 1'h1;
    load_pos = 32'h190;
    @(posedge mclk) #1 load = 1'h0;
    repeat (3) @(posedge mclk);
    #1;
    chk1("fault", 1'h1, fault);
    chk1("busy", 1'h0, busy);
    chk1("valid", 1'h0, home_valid);
    $display("test_fault done");
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge mclk);
    #1;
    srst = 1'h0;
    test_clear_start();
    test_home_start();
    test_limit_start();
    test_abort();
    test_fault();
    tally_and_finish();
  end
endmodule // test_hsq_homing_seq

bind hsq_homing_seq hsq_homing_seq_sva #(.SPEED_W(SPEED_W), .POS_W(POS_W))
  hsq_homing_seq_sva_inst (.mclk(mclk), .srst(srst), .start(start), .abort(abort),
  .mode(mode), .fast_speed(fast_speed), .creep_speed(creep_speed), .sw(sw),
  .axis_pos(axis_pos), .motion(motion), .speed(speed), .busy(busy), .done(done),
  .fault(fault), .home_pos(home_pos), .home_valid(home_valid));
`default_nettype wire
